// ==== verification/tb_top.sv ====
// self-checking bench of the timing lock block
`timescale 1ns/1ps
`include "tlf_map.vh"
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg rd_d = 1'b0;
  reg [7:0] slot_enabled = 8'h00;
  reg [2:0] refs = 3'h0;
  reg cv_good = 1'b0;
  reg [21:0] fn_d = 22'h0;
  reg [31:0] exp_q [$];
  reg [31:0] rnd = 32'd43568;
  wire [31:0] rdata;
  wire irq, line_present, opt_fail, bus_sync_present, bus_strobe_in, bus_drive, bus_loop_closed;
  wire int_strobe, limited_service, locked, lock_fault;
  wire [15:0] osc_ctrl;
  wire [21:0] central_fn, bus_fn_in, frame_count, bus_fn_out, int_fn;
  wire [7:0] slot_reconfig;
  integer fail_count = 0;
  integer cmp_count = 0;
  integer m5, mn, mr, s;
  // clock at 200 MHz
  initial forever #2.5 clk = ~clk;
  tlf_top #(.TIMEOUT_CYC(64'd200), .LIMITED_CYC(64'd120), .FRAME_PERIOD(12'h064)) DUT (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq), .line_present(line_present), .opt_fail(opt_fail),
    .bus_sync_present(bus_sync_present), .osc_ctrl(osc_ctrl), .central_fn(central_fn),
    .bus_fn_in(bus_fn_in), .bus_strobe_in(bus_strobe_in), .slot_enabled(slot_enabled),
    .frame_count(frame_count), .bus_fn_out(bus_fn_out), .bus_drive(bus_drive),
    .bus_loop_closed(bus_loop_closed), .int_strobe(int_strobe), .int_fn(int_fn),
    .limited_service(limited_service), .locked(locked), .lock_fault(lock_fault),
    .slot_reconfig(slot_reconfig));
  tlf_peer #(.PER(100)) u_peer (.clk(clk), .refs(refs), .cv_good(cv_good),
    .line_present(line_present), .opt_fail(opt_fail), .bus_sync_present(bus_sync_present),
    .osc_ctrl(osc_ctrl), .central_fn(central_fn), .bus_fn_in(bus_fn_in),
    .bus_strobe_in(bus_strobe_in));
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [31:0] seen, input [31:0] want);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== want) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a, input [31:0] e);
    begin
      @(posedge clk);
      exp_q.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
    end
  endtask
  // cycles from a bus strobe to the next internal strobe
  task meas(output integer m);
    begin
      @(posedge bus_strobe_in);
      m = 0;
      while (int_strobe !== 1'b1 && m < 300) begin
        @(posedge clk);
        m = m + 1;
      end
    end
  endtask
  // compensation is loaded while disabled in slave mode, then enabled
  task comp_run(input [31:0] c, output integer m);
    begin
      wr_reg(`TLF_REG_CTRL, 32'h0);
      wr_reg(`TLF_REG_COMP, c);
      wr_reg(`TLF_REG_CTRL, 32'h21);
      wt(150);
      meas(m);
    end
  endtask
  task print_verdict;
    begin
      if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // read data checker, one cycle behind the strobe
  always @(posedge clk) begin
    rd_d <= rd;
    fn_d <= central_fn;
    if (rd_d) chk(rdata, exp_q.pop_front());
  end
  // watchdog
  initial begin
    #100000;
    fail_count = fail_count + 1;
    print_verdict;
  end
  // main sequence
  initial begin
    wt(20);
    rst <= 1'b0;
    rd_reg(`TLF_REG_CTRL, 32'h0);
    rd_reg(`TLF_REG_MASK, 32'h0);
    rd_reg(8'h1c, 32'h0);
    wr_reg(`TLF_REG_CTRL, 32'h3);
    wt(4);
    chk(bus_drive, 1'b1);
    chk(bus_fn_out, fn_d);
    chk(bus_loop_closed, 1'b1);
    wr_reg(`TLF_REG_CTRL, 32'h1);
    wr_reg(`TLF_REG_COMP, 32'h7);
    wt(4);
    chk(bus_drive, 1'b1);
    rd_reg(`TLF_REG_CTRL, 32'h3);
    rd_reg(`TLF_REG_STATUS, 32'h8);
    wr_reg(`TLF_REG_CTRL, 32'h0);
    wt(4);
    chk(bus_drive, 1'b0);
    chk(bus_loop_closed, 1'b0);
    rnd = xs(rnd);
    slot_enabled <= rnd[7:0] | 8'h01;
    wr_reg(`TLF_REG_OFFSET, 32'h5);
    wt(1);
    chk(slot_reconfig, 8'h00);
    rd_reg(`TLF_REG_STATUS, 32'h8);
    slot_enabled <= 8'h00;
    rnd = xs(rnd);
    wr_reg(`TLF_REG_OFFSET, rnd & 32'h3fffff);
    wt(1);
    chk(slot_reconfig, 8'hff);
    wt(2);
    chk(frame_count, {10'h0, fn_d + rnd[21:0]});
    rd_reg(`TLF_REG_OFFSET, rnd & 32'h3fffff);
    comp_run(32'h5, m5);
    wt(3);
    chk(int_fn, bus_fn_in);
    comp_run(32'hffd, mn);
    chk((m5 - mn + 100) % 100, 8);
    wr_reg(`TLF_REG_COMP, 32'h1);
    rd_reg(`TLF_REG_STATUS, 32'h8);
    meas(mr);
    chk((mr - mn + 100) % 100, 0);
    refs <= 3'h7;
    wr_reg(`TLF_REG_CTRL, 32'h05);
    wt(60);
    chk(locked, 1'b0);
    wr_reg(`TLF_REG_MASK, 32'h1);
    cv_good <= 1'b1;
    for (s = 0; s < 3; s = s + 1) begin
      refs <= ~(3'h1 << s);
      wr_reg(`TLF_REG_CTRL, 32'h05 | (s << 4));
      wt(215);
      chk(locked, 1'b0);
      chk(lock_fault, 1'b1);
      chk(limited_service, 1'b1);
      refs <= 3'h7;
      wt(40);
      chk(locked, 1'b1);
      chk(irq, 1'b1);
      rd_reg(`TLF_REG_STATUS, 32'h7);
      wt(3);
      chk(irq, 1'b0);
    end
    print_verdict;
  end
endmodule // tb_top

// ==== verification/tlf_peer.sv ====
// far side model: reference pins, control value and sync bus
`timescale 1ns/1ps
module tlf_peer #(
  parameter PER = 100
) (
  input wire clk,
  input wire [2:0] refs,
  input wire cv_good,
  output reg line_present = 1'b0,
  output reg opt_fail = 1'b1,
  output reg bus_sync_present = 1'b0,
  output reg [15:0] osc_ctrl = 16'hffff,
  output reg [21:0] central_fn = 22'h0,
  output reg [21:0] bus_fn_in = 22'h0,
  output reg bus_strobe_in = 1'b0
);
  integer ph = 0;
  // health levels; an unsettled loop sits at the rail
  always @(posedge clk) begin
    line_present <= refs[0];
    opt_fail <= !refs[1];
    bus_sync_present <= refs[2];
    osc_ctrl <= cv_good ? 16'h8000 : 16'hffff;
  end
  // strobe four cycles wide so the pin filter keeps it
  always @(posedge clk) begin
    ph <= (ph == PER - 1) ? 0 : ph + 1;
    bus_strobe_in <= ph < 4;
    if (ph == PER - 1) begin
      central_fn <= central_fn + 22'h1;
      bus_fn_in <= central_fn + 22'h00abce; // peer count differs from ours
    end
  end
endmodule // tlf_peer

// ==== verification/tlf_top_asserts.sv ====
// port checker of the timing lock block
`timescale 1ns/1ps
`include "tlf_map.vh"
module tlf_top_asserts #(
  parameter SLOTS = 8,
  parameter [63:0] TIMEOUT_CYC = 64'd200,
  parameter [63:0] LIMITED_CYC = 64'd120
) (
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire [15:0] osc_ctrl,
  input wire [SLOTS-1:0] slot_enabled,
  input wire bus_drive,
  input wire bus_loop_closed,
  input wire limited_service,
  input wire locked,
  input wire lock_fault,
  input wire [SLOTS-1:0] slot_reconfig
);
  reg [63:0] age_q;
  // cycles since the latest start request
  always @(posedge clk) begin
    if (rst || (wr && addr == `TLF_REG_CTRL && wdata[`TLF_CTRL_START])) age_q <= 64'h0;
    else age_q <= age_q + 64'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_win;
    $rose(locked) |-> $past(osc_ctrl) > `TLF_CV_MARGIN && $past(osc_ctrl) < ~`TLF_CV_MARGIN;
  endproperty
  a_win: assert property (p_win) else $error("lock outside window");
  property p_tmo;
    $rose(lock_fault) |-> age_q >= TIMEOUT_CYC && age_q <= TIMEOUT_CYC + 64'd8;
  endproperty
  a_tmo: assert property (p_tmo) else $error("fault off time");
  property p_lim;
    $rose(limited_service) |-> age_q <= LIMITED_CYC + 64'd8;
  endproperty
  a_lim: assert property (p_lim) else $error("limited late");
  property p_on;
    $rose(bus_drive) |-> $past(wr, 2) && $past(addr, 2) == `TLF_REG_CTRL
      && $past(wdata[1:0], 2) == 2'h3;
  endproperty
  a_on: assert property (p_on) else $error("drive without master");
  property p_off;
    $fell(bus_drive) |-> $past(wr, 2) && $past(addr, 2) == `TLF_REG_CTRL && !$past(wdata[0], 2);
  endproperty
  a_off: assert property (p_off) else $error("drive dropped");
  property p_loop;
    bus_drive == bus_loop_closed;
  endproperty
  a_loop: assert property (p_loop) else $error("loop differs");
  property p_rd;
    !$past(rd) |-> rdata == 32'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
  property p_cfg;
    slot_reconfig != 0 |-> slot_reconfig == {SLOTS{1'b1}} && $past(wr)
      && $past(addr) == `TLF_REG_OFFSET && $past(slot_enabled) == 0;
  endproperty
  a_cfg: assert property (p_cfg) else $error("bad reconfig");
endmodule // tlf_top_asserts
bind tlf_top tlf_top_asserts #(.SLOTS(SLOTS), .TIMEOUT_CYC(TIMEOUT_CYC),
  .LIMITED_CYC(LIMITED_CYC)) u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .osc_ctrl(osc_ctrl), .slot_enabled(slot_enabled),
  .bus_drive(bus_drive), .bus_loop_closed(bus_loop_closed), .limited_service(limited_service),
  .locked(locked), .lock_fault(lock_fault), .slot_reconfig(slot_reconfig));

// ==== verilog/tlf_delay.v ====
// signed compensation of the internal timing strobe against the sync-bus strobe
`timescale 1ns/1ps
module tlf_delay #(
  parameter CW = 12
) (
  input wire clk,
  input wire rst,
  input wire strobe_in,
  input wire signed [CW-1:0] comp,
  input wire [CW-1:0] period,
  output reg strobe_out
);
  reg [CW-1:0] cnt_q;
  reg run_q;
  reg [CW-1:0] tgt;
  // positive value delays, negative value fires that many cycles before the next bus strobe
  always @* begin
    if (comp[CW-1]) begin
      tgt = period + comp;
    end else begin
      tgt = comp;
    end
  end
  // count from each bus strobe and fire at the target phase
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= {CW{1'b0}};
      run_q <= 1'b0;
      strobe_out <= 1'b0;
    end else begin
      strobe_out <= 1'b0;
      if (strobe_in) begin
        cnt_q <= {CW{1'b0}};
        run_q <= 1'b1;
        strobe_out <= (tgt == {CW{1'b0}});
      end else if (run_q) begin
        cnt_q <= cnt_q + 1'b1;
        if (cnt_q + 1'b1 == tgt) begin
          strobe_out <= 1'b1;
        end
      end
    end
  end
endmodule // tlf_delay

// ==== verilog/tlf_map.vh ====
// register map, field positions, reset values and timing constants of the timing lock block
`ifndef TLF_MAP_VH
`define TLF_MAP_VH
// register offsets (byte addresses)
`define TLF_REG_CTRL 8'h00
`define TLF_REG_STATUS 8'h04
`define TLF_REG_MASK 8'h08
`define TLF_REG_COMP 8'h0c
`define TLF_REG_OFFSET 8'h10
`define TLF_REG_LOCK 8'h14
`define TLF_REG_SLOTS 8'h18
// ctrl fields
`define TLF_CTRL_EN 0
`define TLF_CTRL_MASTER 1
`define TLF_CTRL_START 2
`define TLF_CTRL_SRC_LO 4
`define TLF_CTRL_SRC_HI 5
// reference source codes
`define TLF_SRC_LINE 2'h0
`define TLF_SRC_OPT 2'h1
`define TLF_SRC_PEER 2'h2
// status bits
`define TLF_ST_LOCKED 0
`define TLF_ST_TIMEOUT 1
`define TLF_ST_LIMITED 2
`define TLF_ST_REFUSED 3
`define TLF_ST_W 4
// reset values
`define TLF_CTRL_RST 8'h00
`define TLF_MASK_RST 4'h0
// control-value window margin and settle count
`define TLF_CV_MARGIN 16'h0100
`define TLF_SETTLE_CYC 5'h10
// timing: minutes and clock rate
`define TLF_CLK_HZ 200000000
`define TLF_TIMEOUT_MIN 6
`define TLF_LIMITED_MIN 4
`define TLF_TIMEOUT_CYC (`TLF_TIMEOUT_MIN * 60 * 64'd`TLF_CLK_HZ)
`define TLF_LIMITED_CYC (`TLF_LIMITED_MIN * 60 * 64'd`TLF_CLK_HZ)
// air timing tolerance in ns
`define TLF_AIR_TOL_NS 920
`endif

// ==== verilog/tlf_sync3.v ====
// three-flop synchroniser with second/third agreement filter
`timescale 1ns/1ps
module tlf_sync3 #(
  parameter W = 1
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  integer i;
  // shift chain, accept a bit once stages two and three agree
  always @(posedge clk) begin
    if (rst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // tlf_sync3

// ==== verilog/tlf_top.v ====
// timing function: lock supervision, frame offset, sync-bus distribution, compensation
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tlf_map.vh"
// Behaviour
// - lock needs control value inside margined window
// - line lock uses presence, timeout, control
// - optional lock uses no-failure, timeout, control
// - peer lock uses bus sync, timeout, control
// - six minute timeout faults, keeps trying
// - limited service at four minutes latest
// - supervision ends once locked
// - frame count is distributed plus offset
// - offset accepted only when slots disabled
// - one offset write reconfigures all slots
// - drive bus when enabled as master
// - stop driving on disable or leaving master
// - compensation taken only slave and disabled
// - positive delays, negative advances internal timing
// - compensation change refused while enabled
// - slave adopts bus frame count
// - carriers aligned within quarter bit; no carrier alignment logic here, only TLF_AIR_TOL_NS is defined
// - refuse change to slave while enabled
module tlf_top #(
  parameter FW = 22,
  parameter CVW = 16,
  parameter CW = 12,
  parameter SLOTS = 8,
  parameter [63:0] TIMEOUT_CYC = `TLF_TIMEOUT_CYC,
  parameter [63:0] LIMITED_CYC = `TLF_LIMITED_CYC,
  parameter [CW-1:0] FRAME_PERIOD = 12'h3e8
) (
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  output reg irq,
  input wire line_present,
  input wire opt_fail,
  input wire bus_sync_present,
  input wire [CVW-1:0] osc_ctrl,
  input wire [FW-1:0] central_fn,
  input wire [FW-1:0] bus_fn_in,
  input wire bus_strobe_in,
  input wire [SLOTS-1:0] slot_enabled,
  output reg [FW-1:0] frame_count,
  output reg [FW-1:0] bus_fn_out,
  output reg bus_drive,
  output reg bus_loop_closed,
  output reg int_strobe,
  output reg [FW-1:0] int_fn,
  output reg limited_service,
  output reg locked,
  output reg lock_fault,
  output reg [SLOTS-1:0] slot_reconfig
);
  localparam ST_IDLE = 3'b001;
  localparam ST_LOCKING = 3'b010;
  localparam ST_LOCKED = 3'b100;
  localparam [CVW-1:0] CV_MAX = {CVW{1'b1}};
  localparam [CVW-1:0] CV_MARGIN = `TLF_CV_MARGIN;
  localparam [4:0] SETTLE = `TLF_SETTLE_CYC;

  // synchronised pins
  wire [2:0] pins_s;
  wire line_s;
  wire opt_fail_s;
  wire bus_sync_s;
  wire bus_strobe_s;
  wire comp_strobe;
  wire bus_strobe_rise;
  reg bus_strobe_prev_q;
  reg [7:0] ctrl_q;
  reg [`TLF_ST_W-1:0] status_q;
  reg [`TLF_ST_W-1:0] mask_q;
  reg [`TLF_ST_W-1:0] ev;
  reg signed [CW-1:0] comp_q;
  reg [FW-1:0] offset_q;
  reg [2:0] state_q;
  reg [63:0] tmr_q;
  reg [4:0] settle_q;
  reg [CVW-1:0] cv_prev_q;
  reg ref_ok;
  reg cv_in_win;
  wire ctrl_wr;
  wire en;
  wire master;
  wire [1:0] src;

  // returns one when a value sits inside the window cut by the margin at both ends
  function in_window;
    input [CVW-1:0] v;
    begin
      in_window = (v > CV_MARGIN) && (v < CV_MAX - CV_MARGIN);
    end
  endfunction

  // returns one on the cycle whose increment makes the timer reach a limit
  function tmr_hit;
    input [63:0] t;
    input [63:0] lim;
    begin
      tmr_hit = (t + 64'h1 == lim);
    end
  endfunction

  // returns one when a control write would turn an enabled master into a slave
  function slave_refused;
    input en_now;
    input master_now;
    input master_new;
    begin
      slave_refused = en_now && master_now && !master_new;
    end
  endfunction

  tlf_sync3 #(
    .W(4)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({bus_strobe_in, bus_sync_present, opt_fail, line_present}),
    .q({bus_strobe_s, pins_s})
  );
  assign line_s = pins_s[0];
  assign opt_fail_s = pins_s[1];
  assign bus_sync_s = pins_s[2];

  // one pulse per bus strobe, so a wide strobe is timed from its leading edge only
  always @(posedge clk) begin
    if (rst) begin
      bus_strobe_prev_q <= 1'b0;
    end else begin
      bus_strobe_prev_q <= bus_strobe_s;
    end
  end
  assign bus_strobe_rise = bus_strobe_s && !bus_strobe_prev_q;

  tlf_delay #(
    .CW(CW)
  ) u_delay (
    .clk(clk),
    .rst(rst),
    .strobe_in(bus_strobe_rise),
    .comp(comp_q),
    .period(FRAME_PERIOD),
    .strobe_out(comp_strobe)
  );

  assign en = ctrl_q[`TLF_CTRL_EN];
  assign master = ctrl_q[`TLF_CTRL_MASTER];
  assign src = ctrl_q[`TLF_CTRL_SRC_HI:`TLF_CTRL_SRC_LO];
  assign ctrl_wr = wr && (addr == `TLF_REG_CTRL);

  // reference qualification per source
  always @* begin
    case (src)
      `TLF_SRC_LINE: ref_ok = line_s;
      `TLF_SRC_OPT: ref_ok = !opt_fail_s;
      `TLF_SRC_PEER: ref_ok = bus_sync_s;
      default: ref_ok = 1'b0;
    endcase
    cv_in_win = in_window(osc_ctrl);
  end

  // control register: a change to slave while enabled is refused
  always @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `TLF_CTRL_RST;
    end else begin
      ctrl_q[`TLF_CTRL_START] <= 1'b0;
      if (ctrl_wr) begin
        ctrl_q[`TLF_CTRL_EN] <= wdata[`TLF_CTRL_EN];
        ctrl_q[`TLF_CTRL_START] <= wdata[`TLF_CTRL_START];
        ctrl_q[`TLF_CTRL_SRC_HI:`TLF_CTRL_SRC_LO] <= wdata[`TLF_CTRL_SRC_HI:`TLF_CTRL_SRC_LO];
        if (!slave_refused(en, master, wdata[`TLF_CTRL_MASTER])) begin
          ctrl_q[`TLF_CTRL_MASTER] <= wdata[`TLF_CTRL_MASTER];
        end
      end
    end
  end

  // compensation and offset registers with their guards
  always @(posedge clk) begin
    if (rst) begin
      comp_q <= {CW{1'b0}};
      offset_q <= {FW{1'b0}};
      slot_reconfig <= {SLOTS{1'b0}};
    end else begin
      slot_reconfig <= {SLOTS{1'b0}};
      if (wr && addr == `TLF_REG_COMP && !en && !master) begin
        comp_q <= wdata[CW-1:0];
      end
      if (wr && addr == `TLF_REG_OFFSET && slot_enabled == {SLOTS{1'b0}}) begin
        offset_q <= wdata[FW-1:0];
        slot_reconfig <= {SLOTS{1'b1}};
      end
    end
  end

  // lock supervision state machine
  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      tmr_q <= 64'h0;
      settle_q <= 5'h0;
      cv_prev_q <= {CVW{1'b0}};
      locked <= 1'b0;
      lock_fault <= 1'b0;
      limited_service <= 1'b0;
    end else begin
      cv_prev_q <= osc_ctrl;
      case (state_q)
        ST_IDLE: begin
          if (ctrl_q[`TLF_CTRL_START]) begin
            state_q <= ST_LOCKING;
            tmr_q <= 64'h0;
            settle_q <= 5'h0;
            lock_fault <= 1'b0;
            limited_service <= 1'b0;
            locked <= 1'b0;
          end
        end
        ST_LOCKING: begin
          if (ctrl_q[`TLF_CTRL_START]) begin
            tmr_q <= 64'h0;
            settle_q <= 5'h0;
            lock_fault <= 1'b0;
            limited_service <= 1'b0;
          end else begin
            if (tmr_q != 64'hffffffffffffffff) begin
              tmr_q <= tmr_q + 64'h1;
            end
            if (tmr_hit(tmr_q, LIMITED_CYC)) begin
              limited_service <= 1'b1;
            end
            if (tmr_hit(tmr_q, TIMEOUT_CYC)) begin
              lock_fault <= 1'b1;
            end
            // settle counter: value in window and steady
            if (ref_ok && cv_in_win && osc_ctrl == cv_prev_q) begin
              if (settle_q == SETTLE - 5'h1) begin
                state_q <= ST_LOCKED;
                locked <= 1'b1;
                limited_service <= 1'b1;
              end else begin
                settle_q <= settle_q + 5'h1;
              end
            end else begin
              settle_q <= 5'h0;
            end
          end
        end
        ST_LOCKED: begin
          if (ctrl_q[`TLF_CTRL_START]) begin
            state_q <= ST_LOCKING;
            tmr_q <= 64'h0;
            settle_q <= 5'h0;
            locked <= 1'b0;
            limited_service <= 1'b0;
            lock_fault <= 1'b0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // frame numbering, sync-bus distribution and slave adoption
  always @(posedge clk) begin
    if (rst) begin
      frame_count <= {FW{1'b0}};
      bus_fn_out <= {FW{1'b0}};
      bus_drive <= 1'b0;
      bus_loop_closed <= 1'b0;
      int_strobe <= 1'b0;
      int_fn <= {FW{1'b0}};
    end else begin
      frame_count <= central_fn + offset_q;
      bus_drive <= en && master;
      bus_loop_closed <= en && master;
      if (en && master) begin
        bus_fn_out <= central_fn;
        int_fn <= central_fn;
      end else if (!master && comp_strobe) begin
        int_fn <= bus_fn_in;
      end
      int_strobe <= master ? 1'b0 : comp_strobe;
    end
  end

  // event capture
  always @* begin
    ev = {`TLF_ST_W{1'b0}};
    ev[`TLF_ST_LOCKED] = (state_q == ST_LOCKING) && (settle_q == SETTLE - 5'h1) &&
      ref_ok && cv_in_win && osc_ctrl == cv_prev_q && !ctrl_q[`TLF_CTRL_START];
    ev[`TLF_ST_TIMEOUT] = (state_q == ST_LOCKING) && tmr_hit(tmr_q, TIMEOUT_CYC) &&
      !ctrl_q[`TLF_CTRL_START];
    ev[`TLF_ST_LIMITED] = (state_q == ST_LOCKING) && tmr_hit(tmr_q, LIMITED_CYC) &&
      !ctrl_q[`TLF_CTRL_START];
    ev[`TLF_ST_REFUSED] = (ctrl_wr && slave_refused(en, master, wdata[`TLF_CTRL_MASTER])) ||
      (wr && addr == `TLF_REG_COMP && (en || master)) ||
      (wr && addr == `TLF_REG_OFFSET && slot_enabled != {SLOTS{1'b0}});
  end

  // sticky status, read clears, a same-cycle event wins over the clear
  always @(posedge clk) begin
    if (rst) begin
      status_q <= {`TLF_ST_W{1'b0}};
      mask_q <= `TLF_MASK_RST;
      irq <= 1'b0;
    end else begin
      if (rd && addr == `TLF_REG_STATUS) begin
        status_q <= ev;
      end else begin
        status_q <= status_q | ev;
      end
      if (wr && addr == `TLF_REG_MASK) begin
        mask_q <= wdata[`TLF_ST_W-1:0];
      end
      irq <= |(status_q & mask_q);
    end
  end

  // read data one cycle after the strobe, zero otherwise and for unmapped addresses
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0;
    end else begin
      rdata <= 32'h0;
      if (rd) begin
        case (addr)
          `TLF_REG_CTRL: rdata <= {24'h0, ctrl_q};
          `TLF_REG_STATUS: rdata <= {{(32-`TLF_ST_W){1'b0}}, status_q};
          `TLF_REG_MASK: rdata <= {{(32-`TLF_ST_W){1'b0}}, mask_q};
          `TLF_REG_COMP: rdata <= {{(32-CW){comp_q[CW-1]}}, comp_q};
          `TLF_REG_OFFSET: rdata <= {{(32-FW){1'b0}}, offset_q};
          `TLF_REG_LOCK: rdata <= {26'h0, lock_fault, limited_service, locked, state_q};
          `TLF_REG_SLOTS: rdata <= {{(32-SLOTS){1'b0}}, slot_enabled};
          default: rdata <= 32'h0;
        endcase
      end
    end
  end
endmodule // tlf_top
